// [include/pbs_pkg.sv]
// Purpose: Constants and types of the PHY bring-up and strap configuration block.
// Assumes: Management frames arrive on the two-wire management pins.
// Notes:   The same register map serves short frames and extended frames.
package pbs_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [15:0] REG_ID_HI = 16'h0002;
  localparam logic [15:0] REG_ID_LO = 16'h0003;
  localparam logic [15:0] REG_CTRL  = 16'h0010;
  localparam logic [15:0] REG_STAT  = 16'h0011;
  localparam logic [15:0] REG_TXADV = 16'h0012;
  localparam logic [4:0]  EXT_DEV   = 5'h1f;

  // ==========================================================================
  // Field positions.
  localparam int CTRL_PD     = 0;
  localparam int CTRL_AN     = 1;
  localparam int CTRL_MST    = 2;
  localparam int CTRL_SRST   = 15;
  localparam int STAT_RDY    = 0;
  localparam int STAT_PD     = 1;
  localparam int STAT_HIABLE = 2;
  localparam int STAT_MIF_LO = 3;
  localparam int STAT_MEDIA  = 5;
  localparam int TXADV_ABL   = 0;
  localparam int TXADV_REQ   = 1;

  // ==========================================================================
  // Reset values and encodings.
  localparam logic       AN_EN_RST = 1'b1;
  localparam logic       PD_RST    = 1'b1;
  localparam logic [1:0] MIF_RMII  = 2'h0;
  localparam logic [1:0] MIF_RGMII = 2'h1;
  localparam logic [1:0] MIF_RSVD  = 2'h2;
  localparam logic [1:0] MIF_MII   = 2'h3;

  // ==========================================================================
  // Timing counts.
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [1:0] SYNC_WAIT    = 2'h3;
  localparam logic [3:0] HDR_LAST     = 4'hc;
  localparam logic [3:0] DATA_LAST    = 4'hf;

  typedef enum logic [1:0] {
    BOOT_CAPT  = 2'b00,
    BOOT_WAIT  = 2'b01,
    BOOT_READY = 2'b10
  } pbs_boot_t;

  typedef enum logic [1:0] {
    MG_IDLE = 2'b00,
    MG_HDR  = 2'b01,
    MG_TA   = 2'b10,
    MG_DATA = 2'b11
  } pbs_mgmt_t;

endpackage

// [logic/pbs_top.sv]
// Purpose: Strap capture, start-up sequencing and management registers of the PHY.
// Assumes: i_sys_clk at 50 MHz; management clock well below a quarter of it.
// Notes:   Pins pass two flip-flops; management clock edges are found by sampling.
//          Straps are taken once, four cycles after each reset ends.
`timescale 1ns/10ps
module pbs_top
  import pbs_pkg::*;
#(
  parameter logic [4:0]  PHY_ADDR       = 5'h00,
  parameter int          STARTUP_CYCLES = 1000,
  parameter logic [15:0] OUI_HI         = 16'h5a3c, // Arbitrary value.
  parameter logic [5:0]  OUI_UPPER      = 6'h15,    // Arbitrary value.
  parameter logic [5:0]  MODEL          = 6'h12,    // Arbitrary value.
  parameter logic [3:0]  REVISION       = 4'h3      // Arbitrary value.
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_mdc,
  input  wire logic       i_mdio_i,
  output logic            o_mdio_o,
  output logic            o_mdio_oe,
  input  wire logic       i_powerdown_after_reset_strap,
  input  wire logic       i_master_pref_strap,
  input  wire logic       i_tx_amplitude_strap,
  input  wire logic       i_mac_if_select_lo,
  input  wire logic       i_mac_if_select_hi,
  input  wire logic       i_media_converter_strap,
  output logic            o_powered_down,
  output logic            o_system_ready,
  output logic            o_link_enable,
  output logic            o_an_enable,
  output logic            o_prefer_master,
  output logic            o_high_level_ability,
  output logic            o_adv_high_ability,
  output logic            o_adv_high_request,
  output logic            o_low_level_only,
  output logic [1:0]      o_mac_if_mode,
  output logic            o_media_converter_en
);

  // ==========================================================================
  // Parameter checks.
  // A zero count would wrap the wait counter and hold ready low for a long time.
  if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535) begin : g_chk
    $error("STARTUP_CYCLES must lie between 1 and 65535.");
  end

  localparam logic [15:0] BOOT_LAST = 16'(STARTUP_CYCLES - 1);

  // ==========================================================================
  // State record.
  typedef struct packed {
    // Pin synchronisers and the management clock edge detector.
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic        mdc_prev;

    // Start-up sequencing.
    pbs_boot_t   boot;
    logic [15:0] bcnt;

    // Configuration captured from the straps and set by the host.
    logic [1:0]  mif;
    logic        mc_strap;
    logic        pd;
    logic        an_en;
    logic        pref_m;
    logic        hi_able;
    logic        adv_abl;
    logic        adv_req;
    logic        low_only;
    logic        ready;
    logic        link_en;
    logic        media_en;

    // Management frame receiver.
    pbs_mgmt_t   mg;
    logic [5:0]  ones;
    logic [3:0]  cnt;
    logic [12:0] hdr;
    logic        rd;
    logic        hit;
    logic        ext;
    logic [1:0]  op;
    logic [15:0] ext_addr;
    logic [15:0] addr;
    logic [15:0] sr;
    logic        mdo;
    logic        mdoe;
  } pbs_state_t;

  pbs_state_t r_ff;
  pbs_state_t nxt_r;

  logic        mdc_s;
  logic        mdio_s;
  logic        mdc_rise;
  logic [12:0] hdr_full;
  logic [15:0] wdata;
  logic [15:0] rdata;

  // Synchronised pins: bit 7 management clock, bit 6 data, then the straps.
  assign mdc_s    = r_ff.sync2[7];
  assign mdio_s   = r_ff.sync2[6];
  assign mdc_rise = mdc_s & ~r_ff.mdc_prev;
  assign hdr_full = {r_ff.hdr[11:0], mdio_s};
  assign wdata    = {r_ff.sr[14:0], mdio_s};

  // ==========================================================================
  // Read data for the address latched at the end of the header.
  always_comb begin
    rdata = 16'h0000;
    // Identifier words read zero until start-up ends, so a host that polls them
    // sees a valid value only once the block is usable.
    if (r_ff.addr == REG_ID_HI) begin
      rdata = r_ff.ready ? OUI_HI : 16'h0000;
    end else if (r_ff.addr == REG_ID_LO) begin
      rdata = r_ff.ready ? {OUI_UPPER, MODEL, REVISION} : 16'h0000;
    end else if (r_ff.addr == REG_CTRL) begin
      rdata[CTRL_PD]  = r_ff.pd;
      rdata[CTRL_AN]  = r_ff.an_en;
      rdata[CTRL_MST] = r_ff.pref_m;
    end else if (r_ff.addr == REG_STAT) begin
      rdata[STAT_RDY]                  = r_ff.ready;
      rdata[STAT_PD]                   = r_ff.pd;
      rdata[STAT_HIABLE]               = r_ff.hi_able;
      rdata[STAT_MIF_LO+1:STAT_MIF_LO] = r_ff.mif;
      rdata[STAT_MEDIA]                = r_ff.media_en;
    end else if (r_ff.addr == REG_TXADV) begin
      rdata[TXADV_ABL] = r_ff.adv_abl;
      rdata[TXADV_REQ] = r_ff.adv_req;
    end
  end

  // ==========================================================================
  // Next state.
  always_comb begin
    nxt_r          = r_ff;
    nxt_r.sync1    = {i_mdc, i_mdio_i, i_powerdown_after_reset_strap,
                      i_master_pref_strap, i_tx_amplitude_strap,
                      i_mac_if_select_hi, i_mac_if_select_lo,
                      i_media_converter_strap};
    nxt_r.sync2    = r_ff.sync1;
    nxt_r.mdc_prev = mdc_s;

    // Start-up: wait until the strap synchronisers hold post-reset levels.
    case (r_ff.boot)
      BOOT_CAPT: begin
        nxt_r.bcnt = r_ff.bcnt + 16'h0001;
        if (r_ff.bcnt[1:0] == SYNC_WAIT) begin
          // Straps are taken once here and never resampled until a reset.
          nxt_r.mif      = r_ff.sync2[2:1];
          nxt_r.mc_strap = r_ff.sync2[0];
          nxt_r.pd       = ~r_ff.sync2[5];
          nxt_r.pref_m   = r_ff.sync2[4];
          nxt_r.hi_able  = ~r_ff.sync2[3];
          nxt_r.adv_abl  = ~r_ff.sync2[3];
          nxt_r.adv_req  = 1'b0;
          nxt_r.an_en    = AN_EN_RST;
          nxt_r.bcnt     = 16'h0000;
          nxt_r.boot     = BOOT_WAIT;
        end
      end
      // Count out the start-up time; identifier reads stay zero meanwhile.
      BOOT_WAIT: begin
        nxt_r.bcnt = r_ff.bcnt + 16'h0001;
        if (r_ff.bcnt == BOOT_LAST) begin
          nxt_r.boot  = BOOT_READY;
          nxt_r.ready = 1'b1;
        end
      end
      // Ready stays set until the next hardware or software reset.
      default: begin
        nxt_r.boot = BOOT_READY;
      end
    endcase

    // Management frame receiver, advanced on each sampled clock rise.
    if (mdc_rise) begin
      case (r_ff.mg)
        // Count preamble ones; a zero after enough of them starts a header.
        MG_IDLE: begin
          nxt_r.mdoe = 1'b0;
          if (mdio_s) begin
            if (r_ff.ones != PREAMBLE_LEN) begin
              nxt_r.ones = r_ff.ones + 6'h01;
            end
          end else if (r_ff.ones == PREAMBLE_LEN) begin
            nxt_r.mg  = MG_HDR;
            nxt_r.cnt = 4'h0;
          end else begin
            nxt_r.ones = 6'h00;
          end
        end
        // Shift in the thirteen header bits that follow the start zero.
        MG_HDR: begin
          nxt_r.hdr = hdr_full;
          nxt_r.cnt = r_ff.cnt + 4'h1;
          if (r_ff.cnt == HDR_LAST) begin
            // Bits: second start bit, opcode, port address, register or device.
            nxt_r.ext = ~hdr_full[12];
            nxt_r.op  = hdr_full[11:10];
            nxt_r.rd  = hdr_full[12] ? (hdr_full[11:10] == 2'b10) : hdr_full[11];
            // Short frames only know read and write; the other two codes are
            // refused so that a stray code cannot write a register.
            nxt_r.hit = (hdr_full[9:5] == PHY_ADDR) &&
                        (hdr_full[12] ? (hdr_full[11] != hdr_full[10])
                                      : (hdr_full[4:0] == EXT_DEV));
            nxt_r.addr = hdr_full[12] ? {11'h000, hdr_full[4:0]} : r_ff.ext_addr;
            nxt_r.cnt  = 4'h0;
            nxt_r.mg   = MG_TA;
          end
        end
        // Two turnaround bits; on reads the device takes the line at the first.
        MG_TA: begin
          nxt_r.cnt = r_ff.cnt + 4'h1;
          if (r_ff.cnt == 4'h0) begin
            // Drive the turnaround zero so it is stable at the host's next rise.
            nxt_r.mdoe = r_ff.rd & r_ff.hit;
            nxt_r.mdo  = 1'b0;
          end else begin
            nxt_r.mdo = rdata[15];
            nxt_r.sr  = {rdata[14:0], 1'b0};
            nxt_r.cnt = 4'h0;
            nxt_r.mg  = MG_DATA;
          end
        end
        // Sixteen data bits: shift reads out and writes in, act on the last one.
        default: begin
          nxt_r.cnt = r_ff.cnt + 4'h1;
          nxt_r.mdo = r_ff.sr[15];
          nxt_r.sr  = r_ff.rd ? {r_ff.sr[14:0], 1'b0} : wdata;
          if (r_ff.cnt == DATA_LAST) begin
            nxt_r.mdoe = 1'b0;
            nxt_r.mdo  = 1'b0;
            nxt_r.ones = 6'h00;
            nxt_r.mg   = MG_IDLE;
            if (r_ff.hit && r_ff.ext && r_ff.op == 2'b00) begin
              nxt_r.ext_addr = wdata;
            end else if (r_ff.hit && r_ff.ext && r_ff.op == 2'b10) begin
              nxt_r.ext_addr = r_ff.ext_addr + 16'h0001;
            end else if (r_ff.hit && !r_ff.rd && r_ff.boot != BOOT_CAPT) begin
              if (r_ff.addr == REG_CTRL) begin
                nxt_r.pd     = wdata[CTRL_PD];
                nxt_r.an_en  = wdata[CTRL_AN];
                nxt_r.pref_m = wdata[CTRL_MST];
                if (wdata[CTRL_SRST]) begin
                  // Software reset reloads every default from the straps.
                  nxt_r.boot  = BOOT_CAPT;
                  nxt_r.bcnt  = 16'h0000;
                  nxt_r.ready = 1'b0;
                  nxt_r.pd    = PD_RST;
                end
              end else if (r_ff.addr == REG_TXADV) begin
                // Without the ability both advertisement bits stay cleared.
                nxt_r.adv_abl = wdata[TXADV_ABL] & r_ff.hi_able;
                nxt_r.adv_req = wdata[TXADV_REQ] & r_ff.hi_able;
              end
            end
          end
        end
      endcase
    end

    // Linking needs start-up done, power-down left and negotiation enabled.
    nxt_r.link_en  = nxt_r.ready & ~nxt_r.pd & nxt_r.an_en;
    nxt_r.media_en = nxt_r.mc_strap & (nxt_r.mif == MIF_RMII);
    // Registered here so that the low-level flag leaves a flip-flop like the rest.
    nxt_r.low_only = ~nxt_r.adv_abl;

    // Reset overrides everything above, a frame that ends this cycle included.
    if (i_rst) begin
      nxt_r       = '0;
      nxt_r.pd    = PD_RST;
      nxt_r.an_en = AN_EN_RST;
    end
  end

  // ==========================================================================
  // State register.
  // Reset is folded into the next-state logic, so this stays a plain register.
  always_ff @(posedge i_sys_clk) begin
    r_ff <= nxt_r;
  end

  // ==========================================================================
  // Outputs, each taken straight from the state register.
  // No output passes through gates, so none can glitch on a state change.
  assign o_mdio_o             = r_ff.mdo;
  assign o_mdio_oe            = r_ff.mdoe;
  assign o_powered_down       = r_ff.pd;
  assign o_system_ready       = r_ff.ready;
  assign o_link_enable        = r_ff.link_en;
  assign o_an_enable          = r_ff.an_en;
  assign o_prefer_master      = r_ff.pref_m;
  assign o_high_level_ability = r_ff.hi_able;
  assign o_adv_high_ability   = r_ff.adv_abl;
  assign o_adv_high_request   = r_ff.adv_req;
  assign o_low_level_only     = r_ff.low_only;
  assign o_mac_if_mode        = r_ff.mif;
  assign o_media_converter_en = r_ff.media_en;

endmodule

// [bench/pbs_top_props.sv]
// Purpose: Port-level checks of strap capture, start-up and advertisement logic.
// Assumes: One clock domain; synchronous active-high reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/10ps
module pbs_top_props
  import pbs_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic       o_powered_down,
  input wire logic       o_system_ready,
  input wire logic       o_link_enable,
  input wire logic       o_an_enable,
  input wire logic       o_high_level_ability,
  input wire logic       o_adv_high_ability,
  input wire logic       o_adv_high_request,
  input wire logic       o_low_level_only,
  input wire logic [1:0] o_mac_if_mode,
  input wire logic       o_media_converter_en
);
  // ==========================================================================
  // Properties. The capture and wait phase keep ready low for a while.
  default clocking cb @(posedge i_sys_clk); endclocking
  sequence s_release; i_rst ##1 !i_rst; endsequence
  sequence s_boot_low; !o_system_ready [*6]; endsequence
  property p_ready_late; s_release |-> s_boot_low; endproperty
  property p_rst_vals;
    i_rst |=> o_powered_down && o_an_enable && !o_system_ready && !o_link_enable;
  endproperty
  property p_link;
    disable iff (i_rst) o_link_enable |-> !($past(o_powered_down) && o_powered_down);
  endproperty
  // Strap-only settings (ability, interface mode, converter) must not move while the block stays ready.
  property p_hold;
    disable iff (i_rst) o_system_ready && $past(o_system_ready) |->
      $stable(o_high_level_ability) && $stable(o_mac_if_mode) && $stable(o_media_converter_en);
  endproperty
  property p_adv_gate;
    disable iff (i_rst) o_adv_high_ability || o_adv_high_request |-> o_high_level_ability;
  endproperty
  property p_low_only;
    disable iff (i_rst) o_system_ready && $stable(o_adv_high_ability) |->
      o_low_level_only != o_adv_high_ability;
  endproperty
  property p_media;
    disable iff (i_rst) o_media_converter_en |-> o_mac_if_mode == MIF_RMII;
  endproperty
  property p_an_def; disable iff (i_rst) $rose(o_system_ready) |-> o_an_enable; endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready too early");
  a_rst_vals: assert property (p_rst_vals) else $error("bad reset values");
  a_link: assert property (p_link) else $error("link while powered down");
  a_hold: assert property (p_hold) else $error("straps changed");
  a_adv_gate: assert property (p_adv_gate) else $error("adv without ability");
  a_low_only: assert property (p_low_only) else $error("low level flag wrong");
  a_media: assert property (p_media) else $error("converter off-mode");
  a_an_def: assert property (p_an_def) else $error("autoneg off at ready");
endmodule
bind pbs_top pbs_top_props i_pbs_top_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .o_powered_down(o_powered_down), .o_system_ready(o_system_ready),
  .o_link_enable(o_link_enable), .o_an_enable(o_an_enable),
  .o_high_level_ability(o_high_level_ability), .o_adv_high_ability(o_adv_high_ability),
  .o_adv_high_request(o_adv_high_request), .o_low_level_only(o_low_level_only),
  .o_mac_if_mode(o_mac_if_mode), .o_media_converter_en(o_media_converter_en));

// [bench/pbs_mdio_host.sv]
// Purpose: Management host model that clocks frames over the two-wire pins.
// Assumes: Clock pin idles low between frames; the data line has a pull-up.
// Notes:   Half a clock pin period is four system clock cycles (160 ns period).
`timescale 1ns/10ps
module pbs_mdio_host (
  input  wire logic i_sys_clk,
  input  wire logic i_mdio_o,
  input  wire logic i_mdio_oe,
  output logic      o_mdc,
  output logic      o_line
);
  logic drv_en;
  logic drv;
  // ==========================================================================
  // Wired line: the device, else the host, else the pull-up level.
  assign o_line = i_mdio_oe ? i_mdio_o : (drv_en ? drv : 1'b1);
  initial begin
    o_mdc = 1'b0;
    drv_en = 1'b0;
    drv = 1'b1;
  end
  // Data changes as the clock pin falls; read bits are taken just before each rise.
  task automatic xfer(input logic [13:0] hdr, input logic [15:0] wd, input bit rd,
                      output logic [15:0] q);
    logic [63:0] f;
    f = {32'hffffffff, hdr, 2'b10, wd};
    @(negedge i_sys_clk);
    for (int i = 0; i < 64; i++) begin
      drv_en = !(rd && i >= 46);
      drv = f[63-i];
      repeat (4) @(negedge i_sys_clk);
      if (i >= 48) q[63-i] = o_line;
      o_mdc = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      o_mdc = 1'b0;
    end
    drv_en = 1'b0;
    repeat (8) @(negedge i_sys_clk);
  endtask
endmodule

// [bench/pbs_top_tb_top.sv]
// Purpose: Self-checking bench for strap capture and management registers.
// Assumes: Straps are driven by the bench in place of board resistors.
// Notes:   A short start-up count keeps the run brief.
`timescale 1ns/10ps
module pbs_top_tb_top
  import pbs_pkg::*;
;
  localparam logic [15:0] ID_HI = 16'h5a3c;             // Arbitrary value.
  localparam logic [15:0] ID_LO = {6'h15, 6'h12, 4'h3}; // Arbitrary value.
  logic        i_sys_clk;
  logic        i_rst;
  logic        mdc;
  logic        mdio_line;
  logic        mdio_o;
  logic        mdio_oe;
  logic [5:0]  strap;
  logic [15:0] rdat;
  logic [1:0]  kk;
  logic        o_powered_down, o_system_ready, o_link_enable, o_an_enable, o_prefer_master;
  logic        o_high_level_ability, o_adv_high_ability, o_adv_high_request, o_low_level_only;
  logic [1:0]  o_mac_if_mode;
  logic        o_media_converter_en;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc_count = 0;
  pbs_top #(.STARTUP_CYCLES(600), .OUI_HI(ID_HI), .OUI_UPPER(ID_LO[15:10]),
    .MODEL(ID_LO[9:4]), .REVISION(ID_LO[3:0])) i_pbs_top (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_mdc(mdc), .i_mdio_i(mdio_line), .o_mdio_o(mdio_o), .o_mdio_oe(mdio_oe),
    .i_powerdown_after_reset_strap(strap[5]), .i_master_pref_strap(strap[4]),
    .i_tx_amplitude_strap(strap[3]), .i_mac_if_select_hi(strap[2]),
    .i_mac_if_select_lo(strap[1]), .i_media_converter_strap(strap[0]),
    .o_powered_down(o_powered_down), .o_system_ready(o_system_ready),
    .o_link_enable(o_link_enable), .o_an_enable(o_an_enable),
    .o_prefer_master(o_prefer_master), .o_high_level_ability(o_high_level_ability),
    .o_adv_high_ability(o_adv_high_ability), .o_adv_high_request(o_adv_high_request),
    .o_low_level_only(o_low_level_only), .o_mac_if_mode(o_mac_if_mode),
    .o_media_converter_en(o_media_converter_en));
  pbs_mdio_host i_pbs_mdio_host (.i_sys_clk(i_sys_clk), .i_mdio_o(mdio_o),
    .i_mdio_oe(mdio_oe), .o_mdc(mdc), .o_line(mdio_line));
  // ==========================================================================
  // Clock and a cycle ceiling that cuts a hang short.
  always #10 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 30000) begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end
  task automatic complete_run;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Headers: short frames use port 0, extended frames the fixed device number.
  function automatic logic [13:0] sh(input logic [1:0] op, input logic [15:0] rg);
    return {2'b01, op, 5'h00, rg[4:0]};
  endfunction
  task automatic mf(input logic [13:0] hdr, input logic [15:0] wd, input bit rd);
    i_pbs_mdio_host.xfer(hdr, wd, rd, rdat);
  endtask
  task automatic hard_rst(input logic [5:0] s);
    @(negedge i_sys_clk);
    strap = s;
    i_rst = 1'b1;
    repeat (5) @(negedge i_sys_clk);
    i_rst = 1'b0;
  endtask
  task automatic wait_rdy;
    for (int n = 0; n < 2000 && o_system_ready !== 1'b1; n++) @(negedge i_sys_clk);
    repeat (2) @(negedge i_sys_clk);
    chk(o_system_ready, 1'b1, "ready");
  endtask
  // Main sequence; strap order is power-down, master, amplitude, select hi, lo, media.
  initial begin
    i_sys_clk = 1'b0;
    i_rst = 1'b1;
    strap = 6'h00;
    hard_rst(6'b010001);
    mf(sh(2'b10, REG_ID_HI), 16'h0000, 1);
    chk(rdat, 16'h0000, "early id");
    wait_rdy;
    mf(sh(2'b10, REG_ID_HI), 16'h0000, 1);
    chk(rdat, ID_HI, "id high");
    mf(sh(2'b10, REG_ID_LO), 16'h0000, 1);
    chk(rdat, ID_LO, "id low");
    mf({2'b00, 2'b00, 5'h00, EXT_DEV}, REG_ID_HI, 0);
    mf({2'b00, 2'b11, 5'h00, EXT_DEV}, 16'h0000, 1);
    chk(rdat, ID_HI, "ext id");
    mf({2'b00, 2'b10, 5'h00, EXT_DEV}, 16'h0000, 1);
    chk(rdat, ID_HI, "ext read step");
    mf({2'b00, 2'b11, 5'h00, EXT_DEV}, 16'h0000, 1);
    chk(rdat, ID_LO, "ext next id");
    mf({2'b01, 2'b10, 5'h01, REG_ID_HI[4:0]}, 16'h0000, 1);
    chk(rdat, 16'hffff, "wrong port");
    mf({2'b00, 2'b11, 5'h00, 5'h1e}, 16'h0000, 1);
    chk(rdat, 16'hffff, "wrong device");
    mf(sh(2'b10, REG_STAT), 16'h0000, 1);
    chk(rdat, 16'h0027, "status");
    strap = 6'b101100;
    repeat (50) @(negedge i_sys_clk);
    chk({o_high_level_ability, o_mac_if_mode, o_powered_down, o_link_enable}, 5'h12,
      "held");
    mf(sh(2'b01, REG_CTRL), 16'h0006, 0);
    chk({o_powered_down, o_link_enable, o_prefer_master, o_an_enable}, 4'b0111,
      "wake");
    mf(sh(2'b01, REG_TXADV), 16'h0003, 0);
    mf(sh(2'b10, REG_TXADV), 16'h0000, 1);
    chk(rdat, 16'h0003, "adv on");
    chk({o_adv_high_ability, o_adv_high_request, o_low_level_only}, 3'b110, "adv");
    strap = 6'b101111;
    mf(sh(2'b01, REG_CTRL), 16'h8000, 0);
    wait_rdy;
    chk({o_powered_down, o_prefer_master, o_high_level_ability, o_mac_if_mode,
      o_media_converter_en, o_link_enable}, 7'b0001101, "soft reset");
    mf(sh(2'b01, REG_TXADV), 16'h0003, 0);
    mf(sh(2'b10, REG_TXADV), 16'h0000, 1);
    chk(rdat, 16'h0000, "adv gated");
    chk(o_low_level_only, 1'b1, "low only");
    for (int k = 0; k < 4; k++) begin
      kk = k[1:0];
      hard_rst({kk[0], kk[1], kk[0], kk, 1'b1});
      wait_rdy;
      chk({o_mac_if_mode, o_media_converter_en, o_prefer_master, o_high_level_ability,
        o_powered_down}, {kk, kk == 2'h0, kk[1], !kk[0], !kk[0]}, "straps");
    end
    complete_run;
  end
endmodule
